// file: ite_map.vh
// Constants for the I2C target emulation engine.
`ifndef ITE_MAP_VH
`define ITE_MAP_VH
`define ITE_ADDR_RESET      7'h00
`define ITE_CMD_LEN_RESET   8'h00
`define ITE_DATA_LEN_RESET  8'h80
`define ITE_WDRAW_RESET     16'h0000
`define ITE_CLK_HZ          125000000
`define ITE_MS_PER_S        1000
`define ITE_MS_CYCLES       17'h1E848
`define ITE_ST_IDLE         3'h0
`define ITE_ST_ADDR         3'h1
`define ITE_ST_ADDR_ACK     3'h2
`define ITE_ST_WR_BYTE      3'h3
`define ITE_ST_WR_ACK       3'h4
`define ITE_ST_RD_BYTE      3'h5
`define ITE_ST_RD_ACK       3'h6
`define ITE_ST_SKIP         3'h7
`endif

// file: ite_target.v
// I2C target emulation engine: address match, write split, read service, withdrawal timer.
`timescale 1ns/100ps
`include "ite_map.vh"

module ite_target (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        start_cmd,
    input  wire        stop_cmd,
    input  wire        cfg_load,
    input  wire [6:0]  cfg_address,
    input  wire [7:0]  cfg_cmd_len,
    input  wire [7:0]  cfg_data_len,
    input  wire [15:0] cfg_withdraw_ms,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        scl_out,
    output wire        scl_oe,
    output wire        sda_out,
    output reg         sda_oe,
    output reg  [7:0]  rx_byte,
    output reg         rx_cmd_valid,
    output reg         rx_data_valid,
    output reg         command_buffer_event,
    output reg         write_data_ready_event,
    output reg         read_data_request_event,
    input  wire [7:0]  tx_byte,
    output reg         read_done_event,
    output reg  [15:0] read_count,
    input  wire        event_ack,
    output reg         on_bus,
    output reg         withdrawn,
    output reg  [6:0]  target_address,
    output reg  [7:0]  cmd_len,
    output reg  [7:0]  data_len
);
    parameter [16:0] MS_CYCLES = `ITE_MS_CYCLES;

    reg         scl_s1;
    reg         scl_s2;
    reg         scl_d;
    reg         sda_s1;
    reg         sda_s2;
    reg         sda_d;
    reg  [2:0]  state;
    reg  [2:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg  [7:0]  cmd_cnt;
    reg  [7:0]  dat_cnt;
    reg         rd_nack;
    reg         got_byte;
    reg  [15:0] wd_setting;
    reg  [15:0] ms_left;
    reg  [16:0] tick_cnt;
    reg         running;

    wire scl_rise   = scl_s2 & ~scl_d;
    wire scl_fall   = ~scl_s2 & scl_d;
    wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire in_write   = (state == `ITE_ST_WR_BYTE) | (state == `ITE_ST_WR_ACK);
    wire in_read    = (state == `ITE_ST_RD_BYTE) | (state == `ITE_ST_RD_ACK);
    wire cmd_room   = (cmd_cnt < cmd_len);
    wire wr_end     = in_write & (start_cond | stop_cond);
    wire rd_end     = in_read & (start_cond | stop_cond);

    // The target never stretches the clock, so SCL is never driven.
    assign scl_out = 1'b0;
    assign scl_oe  = 1'b0;
    assign sda_out = 1'b0;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // Configuration is taken only while stopped so a live transfer keeps its split.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            target_address <= `ITE_ADDR_RESET;
            cmd_len        <= `ITE_CMD_LEN_RESET;
            data_len       <= `ITE_DATA_LEN_RESET;
            wd_setting     <= `ITE_WDRAW_RESET;
        end else if (cfg_load && !running) begin
            target_address <= cfg_address;
            cmd_len        <= cfg_cmd_len;
            data_len       <= cfg_data_len;
            wd_setting     <= cfg_withdraw_ms;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            running   <= 1'b0;
            withdrawn <= 1'b0;
            ms_left   <= 16'h0000;
            tick_cnt  <= 17'h00000;
        end else if (stop_cmd) begin
            running   <= 1'b0;
            withdrawn <= 1'b0;
        end else if (start_cmd) begin
            running   <= 1'b1;
            withdrawn <= 1'b0;
        end else if (wr_end && wd_setting != 16'h0000) begin
            if (wd_setting[15]) begin
                running <= 1'b0;
            end else begin
                withdrawn <= 1'b1;
                ms_left   <= wd_setting;
                tick_cnt  <= 17'h00000;
            end
        end else if (withdrawn) begin
            if (tick_cnt == MS_CYCLES - 17'h00001) begin
                tick_cnt <= 17'h00000;
                if (ms_left == 16'h0001) begin
                    withdrawn <= 1'b0;
                end
                ms_left <= ms_left - 16'h0001;
            end else begin
                tick_cnt <= tick_cnt + 17'h00001;
            end
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            on_bus <= 1'b0;
        end else begin
            on_bus <= running & ~withdrawn & ~stop_cmd;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state         <= `ITE_ST_IDLE;
            bit_cnt       <= 3'h0;
            shreg         <= 8'h00;
            sda_oe        <= 1'b0;
            cmd_cnt       <= 8'h00;
            dat_cnt       <= 8'h00;
            rd_nack       <= 1'b0;
            got_byte      <= 1'b0;
            rx_byte       <= 8'h00;
            rx_cmd_valid  <= 1'b0;
            rx_data_valid <= 1'b0;
            read_count    <= 16'h0000;
        end else begin
            rx_cmd_valid  <= 1'b0;
            rx_data_valid <= 1'b0;
            if (!on_bus) begin
                state  <= `ITE_ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state    <= `ITE_ST_ADDR;
                bit_cnt  <= 3'h0;
                got_byte <= 1'b0;
                sda_oe  <= 1'b0;
                cmd_cnt <= 8'h00;
                dat_cnt <= 8'h00;
            end else if (stop_cond) begin
                state  <= `ITE_ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    `ITE_ST_ADDR, `ITE_ST_WR_BYTE: begin
                        // A decision waits for eight shifted bits, so the fall that ends a start is ignored.
                        if (scl_rise) begin
                            shreg    <= {shreg[6:0], sda_s2};
                            bit_cnt  <= bit_cnt + 3'h1;
                            got_byte <= (bit_cnt == 3'h7);
                        end
                        if (scl_fall && got_byte) begin
                            if (state == `ITE_ST_ADDR) begin
                                // Header 11110xx never equals a 7-bit address here.
                                if (shreg[7:1] == target_address && shreg[7:3] != 5'h1E) begin
                                    sda_oe <= 1'b1;
                                    state  <= `ITE_ST_ADDR_ACK;
                                end else begin
                                    state  <= `ITE_ST_SKIP;
                                end
                            end else begin
                                rx_byte <= shreg;
                                sda_oe  <= 1'b1;
                                state   <= `ITE_ST_WR_ACK;
                                if (cmd_room) begin
                                    rx_cmd_valid <= 1'b1;
                                    cmd_cnt      <= cmd_cnt + 8'h01;
                                end else begin
                                    rx_data_valid <= 1'b1;
                                    dat_cnt       <= (dat_cnt + 8'h01 == data_len) ? 8'h00
                                                     : dat_cnt + 8'h01;
                                end
                            end
                        end
                    end
                    `ITE_ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (shreg[0]) begin
                                state      <= `ITE_ST_RD_BYTE;
                                read_count <= 16'h0000;
                                sda_oe     <= ~tx_byte[7];
                                shreg      <= {tx_byte[6:0], 1'b0};
                            end else begin
                                state  <= `ITE_ST_WR_BYTE;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    `ITE_ST_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe  <= 1'b0;
                            bit_cnt <= 3'h0;
                            state   <= `ITE_ST_WR_BYTE;
                        end
                    end
                    `ITE_ST_RD_BYTE: begin
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                sda_oe     <= 1'b0;
                                state      <= `ITE_ST_RD_ACK;
                                read_count <= read_count + 16'h0001;
                            end else begin
                                sda_oe <= ~shreg[7];
                                shreg  <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                    `ITE_ST_RD_ACK: begin
                        if (scl_rise) begin
                            rd_nack <= sda_s2;
                        end
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (rd_nack) begin
                                state <= `ITE_ST_SKIP;
                            end else begin
                                state  <= `ITE_ST_RD_BYTE;
                                sda_oe <= ~tx_byte[7];
                                shreg  <= {tx_byte[6:0], 1'b0};
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Event flags are sticky; a new event in the acknowledge cycle wins.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            command_buffer_event    <= 1'b0;
            write_data_ready_event  <= 1'b0;
            read_data_request_event <= 1'b0;
            read_done_event         <= 1'b0;
        end else if (stop_cmd) begin
            // Only a stop discards events; a halt keeps the events of the write that caused it.
            command_buffer_event    <= 1'b0;
            write_data_ready_event  <= 1'b0;
            read_data_request_event <= 1'b0;
            read_done_event         <= 1'b0;
        end else begin
            if ((rx_cmd_valid && cmd_cnt == cmd_len) ||
                (wr_end && cmd_cnt != 8'h00 && cmd_room)) begin
                command_buffer_event <= 1'b1;
            end else if (event_ack) begin
                command_buffer_event <= 1'b0;
            end
            if ((rx_data_valid && dat_cnt == 8'h00) || (wr_end && dat_cnt != 8'h00)) begin
                write_data_ready_event <= 1'b1;
            end else if (event_ack) begin
                write_data_ready_event <= 1'b0;
            end
            if ((state == `ITE_ST_ADDR_ACK && scl_fall && shreg[0]) ||
                (state == `ITE_ST_RD_ACK && scl_fall && !rd_nack)) begin
                read_data_request_event <= 1'b1;
            end else if (event_ack) begin
                read_data_request_event <= 1'b0;
            end
            if (rd_end || (state == `ITE_ST_RD_ACK && scl_fall && rd_nack)) begin
                read_done_event <= 1'b1;
            end else if (event_ack) begin
                read_done_event <= 1'b0;
            end
        end
    end
endmodule // ite_target

// file: ite_bus_master.sv
// Bit-level I2C bus master model that pulls the open-drain lines low.
`timescale 1ns/100ps
module ite_bus_master (
    input  wire  sys_clk,
    input  wire  scl,
    input  wire  sda,
    output logic scl_low,
    output logic sda_low
);
    logic spare;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic qtr;
        repeat (2) @(negedge sys_clk);
    endtask
    // One 64 ns clock period: data moves mid-low, the line is read just before SCL falls.
    task automatic frame_bit(input logic d1, input logic d2, input logic hold, output logic r);
        qtr;
        sda_low = d1;
        qtr;
        scl_low = 1'b0;
        qtr;
        sda_low = d2;
        qtr;
        r = sda;
        scl_low = hold;
    endtask
    task automatic start;
        frame_bit(1'b0, 1'b1, 1'b1, spare);
    endtask
    // The clock is released at the end, so it stands still high between frames.
    task automatic stop;
        frame_bit(1'b1, 1'b0, 1'b0, spare);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            frame_bit(~d[i], ~d[i], 1'b1, r);
        frame_bit(1'b0, 1'b0, 1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            frame_bit(1'b0, 1'b0, 1'b1, d[i]);
        frame_bit(~last, ~last, 1'b1, r);
    endtask
endmodule // ite_bus_master

// file: ite_target_sva.sv
// Concurrent checks on the ports of the I2C target emulation engine.
`timescale 1ns/100ps
module ite_target_sva #(
    parameter [16:0] MS_CYCLES = 17'h1E848
) (
    input wire        sys_clk,
    input wire        reset_n,
    input wire        start_cmd,
    input wire        stop_cmd,
    input wire        event_ack,
    input wire [15:0] cfg_withdraw_ms,
    input wire        scl_oe,
    input wire        sda_oe,
    input wire        rx_cmd_valid,
    input wire        rx_data_valid,
    input wire        command_buffer_event,
    input wire        write_data_ready_event,
    input wire        read_data_request_event,
    input wire        read_done_event,
    input wire        on_bus,
    input wire        withdrawn,
    input wire [6:0]  target_address
);
    reg  [31:0] wd_cnt;
    wire [31:0] wd_limit = cfg_withdraw_ms * MS_CYCLES;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            wd_cnt <= 32'h0;
        else
            wd_cnt <= withdrawn ? wd_cnt + 32'h1 : 32'h0;
    end
    chk_scl_released: assert property (!scl_oe)
        else $error("clock line driven");
    chk_quiet_withdrawn: assert property (withdrawn && $past(withdrawn) |-> !sda_oe)
        else $error("data line driven while withdrawn");
    chk_quiet_off_bus: assert property (!on_bus && !$past(on_bus) |-> !sda_oe)
        else $error("data line driven while off the bus");
    chk_stop_clears: assert property (stop_cmd |=> !on_bus && !command_buffer_event
        && !write_data_ready_event && !read_data_request_event && !read_done_event)
        else $error("stop left the target active");
    chk_cmd_event_held: assert property ($fell(command_buffer_event)
        |-> $past(event_ack) || $past(stop_cmd)) else $error("command event lost");
    chk_data_event_held: assert property ($fell(write_data_ready_event)
        |-> $past(event_ack) || $past(stop_cmd)) else $error("data event lost");
    chk_request_held: assert property ($fell(read_data_request_event)
        |-> $past(event_ack) || $past(stop_cmd)) else $error("request event lost");
    chk_done_held: assert property ($fell(read_done_event)
        |-> $past(event_ack) || $past(stop_cmd)) else $error("read done event lost");
    chk_rx_split: assert property (!(rx_cmd_valid && rx_data_valid))
        else $error("byte marked command and data");
    chk_withdraw_length: assert property ($fell(withdrawn) && !$past(stop_cmd)
        && !$past(start_cmd) |-> wd_cnt == wd_limit) else $error("withdrawal length wrong");
    chk_start_joins: assert property (start_cmd && !stop_cmd |-> ##[1:2] on_bus)
        else $error("start did not join the bus");
    chk_address_locked: assert property (on_bus && $past(on_bus)
        |-> $stable(target_address)) else $error("address changed while on the bus");
endmodule // ite_target_sva
bind ite_target ite_target_sva #(.MS_CYCLES(MS_CYCLES)) ite_target_sva_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .event_ack(event_ack), .cfg_withdraw_ms(cfg_withdraw_ms), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .rx_cmd_valid(rx_cmd_valid), .rx_data_valid(rx_data_valid),
    .command_buffer_event(command_buffer_event), .read_done_event(read_done_event),
    .write_data_ready_event(write_data_ready_event), .on_bus(on_bus),
    .read_data_request_event(read_data_request_event), .withdrawn(withdrawn),
    .target_address(target_address));

// file: ite_target_bench.sv
// Self-checking bench for the I2C target emulation engine.
`timescale 1ns/100ps
`define ITE_CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module ite_target_bench;
    logic        sys_clk         = 1'b0;
    logic        reset_n         = 1'b0;
    logic        start_cmd       = 1'b0;
    logic        stop_cmd        = 1'b0;
    logic        cfg_load        = 1'b0;
    logic        event_ack       = 1'b0;
    logic [6:0]  cfg_address     = 7'h00;
    logic [7:0]  cfg_cmd_len     = 8'h00;
    logic [7:0]  cfg_data_len    = 8'h03;
    logic [15:0] cfg_withdraw_ms = 16'h0000;
    logic [7:0]  tx_byte         = 8'hC6;
    logic [8:0]  rx_q[$];
    int          bad_count       = 0;
    int          comparisons     = 0;
    int          cycles          = 0;
    wire         scl, sda, m_scl_low, m_sda_low, scl_oe, sda_oe, on_bus, withdrawn;
    wire         rx_cmd_valid, rx_data_valid, ev_cmd, ev_data, ev_req, ev_done;
    wire [7:0]   rx_byte, cmd_len, data_len;
    wire [6:0]   target_address;
    wire [15:0]  read_count;
    assign scl = ~(m_scl_low | scl_oe);
    assign sda = ~(m_sda_low | sda_oe);
    always #4 sys_clk = ~sys_clk;
    ite_target #(.MS_CYCLES(17'h0000A)) ite_target_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .cfg_load(cfg_load),
        .cfg_address(cfg_address), .cfg_cmd_len(cfg_cmd_len), .cfg_data_len(cfg_data_len),
        .cfg_withdraw_ms(cfg_withdraw_ms), .scl_in(scl), .sda_in(sda), .scl_out(),
        .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .rx_byte(rx_byte),
        .rx_cmd_valid(rx_cmd_valid), .rx_data_valid(rx_data_valid),
        .command_buffer_event(ev_cmd), .write_data_ready_event(ev_data),
        .read_data_request_event(ev_req), .tx_byte(tx_byte), .read_done_event(ev_done),
        .read_count(read_count), .event_ack(event_ack), .on_bus(on_bus),
        .withdrawn(withdrawn), .target_address(target_address), .cmd_len(cmd_len),
        .data_len(data_len));
    ite_bus_master ite_bus_master_i (.sys_clk(sys_clk), .scl(scl), .sda(sda),
        .scl_low(m_scl_low), .sda_low(m_sda_low));
    task automatic conclude;
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (rx_cmd_valid)
            rx_q.push_back({1'b1, rx_byte});
        if (rx_data_valid)
            rx_q.push_back({1'b0, rx_byte});
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic strobe(input logic st, input logic sp, input logic ea);
        @(negedge sys_clk);
        {start_cmd, stop_cmd, event_ack} = {st, sp, ea};
        @(negedge sys_clk);
        {start_cmd, stop_cmd, event_ack} = 3'h0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic setup(input logic [6:0] a, input logic [7:0] cl, input logic [15:0] wms);
        strobe(1'b0, 1'b1, 1'b0);
        {cfg_address, cfg_cmd_len, cfg_withdraw_ms} = {a, cl, wms};
        cfg_load = 1'b1;
        @(negedge sys_clk);
        cfg_load = 1'b0;
        strobe(1'b1, 1'b0, 1'b0);
        rx_q.delete();
    endtask
    task automatic wr(input logic [6:0] a, input int n, input logic exp_ack);
        logic ack;
        ite_bus_master_i.start();
        ite_bus_master_i.send({a, 1'b0}, ack);
        `ITE_CHECK(ack, exp_ack)
        for (int i = 0; i < n && ack; i++)
            ite_bus_master_i.send(8'h10 + i[7:0], ack);
        ite_bus_master_i.stop();
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic t_reset;
        `ITE_CHECK({target_address, cmd_len, on_bus}, 16'h0000)
        `ITE_CHECK(data_len, 8'h80)
    endtask
    task automatic t_split;
        setup(7'h5A, 8'h02, 16'h0000);
        wr(7'h5A, 5, 1'b1);
        for (int i = 0; i < 5; i++)
            `ITE_CHECK(rx_q[i], {i < 2, 8'h10 + i[7:0]})
        `ITE_CHECK({ev_cmd, ev_data}, 2'b11)
        strobe(1'b0, 1'b0, 1'b1);
        wr(7'h5A, 1, 1'b1);
        `ITE_CHECK({ev_cmd, ev_data}, 2'b10)
        wr(7'h5B, 0, 1'b0);
    endtask
    task automatic t_nocmd;
        setup(7'h33, 8'h00, 16'h0000);
        wr(7'h33, 2, 1'b1);
        `ITE_CHECK(rx_q[1], 9'h011)
        `ITE_CHECK({ev_cmd, ev_data}, 2'b01)
        setup(7'h78, 8'h00, 16'h0000);
        wr(7'h78, 0, 1'b0);
    endtask
    task automatic t_read;
        logic       ack;
        logic [7:0] d;
        setup(7'h21, 8'h00, 16'h0000);
        ite_bus_master_i.start();
        ite_bus_master_i.send({7'h21, 1'b1}, ack);
        for (int i = 0; i < 3; i++) begin
            ite_bus_master_i.recv(i == 2, d);
            `ITE_CHECK({ack, d}, 9'h1C6)
        end
        ite_bus_master_i.stop();
        repeat (4) @(negedge sys_clk);
        `ITE_CHECK({ev_req, ev_done, read_count}, 18'h30003)
    endtask
    task automatic t_withdraw;
        setup(7'h5A, 8'h00, 16'h000A);
        wr(7'h5A, 1, 1'b1);
        `ITE_CHECK(withdrawn, 1'b1)
        wr(7'h5A, 0, 1'b0);
        for (int i = 0; i < 400 && withdrawn; i++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        `ITE_CHECK({withdrawn, on_bus}, 2'b01)
        wr(7'h5A, 0, 1'b1);
    endtask
    task automatic t_halt;
        setup(7'h5A, 8'h00, 16'hFFFF);
        wr(7'h5A, 1, 1'b1);
        `ITE_CHECK(on_bus, 1'b0)
        wr(7'h5A, 0, 1'b0);
        strobe(1'b1, 1'b0, 1'b0);
        wr(7'h5A, 1, 1'b1);
    endtask
    task automatic t_stop;
        `ITE_CHECK(ev_data, 1'b1)
        strobe(1'b0, 1'b1, 1'b0);
        `ITE_CHECK({on_bus, ev_cmd, ev_data, ev_req, ev_done}, 5'h00)
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        t_reset();
        t_split();
        t_nocmd();
        t_read();
        t_withdraw();
        t_halt();
        t_stop();
        conclude();
    end
endmodule // ite_target_bench
